// ==== sap_pkg.sv ====
`default_nettype none

package sap_pkg;

	// ****************************************************************
	// word layout
	// ****************************************************************
	localparam int RESULT_W = 10;
	localparam int TAG_W = 4;
	localparam int CH_W = 3;
	localparam int WORD_W = TAG_W + RESULT_W;
	localparam int CFG_W = 16;
	localparam int FRAME_BITS = 16;
	localparam int BIT_CNT_W = 4;
	localparam int SAR_IDX_W = 4;
	localparam int CFG_CH_LSB = 0;
	localparam int PAD_W = FRAME_BITS - WORD_W;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [CFG_W-1:0] CFG_RESET = 16'h0000;
	localparam logic [RESULT_W-1:0] SAR_FIRST_TRIAL = 10'h200;
	localparam logic [SAR_IDX_W-1:0] SAR_FIRST_IDX = 4'h9;
	localparam logic [BIT_CNT_W-1:0] BIT_CNT_LAST = 4'hf;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_PERIOD_PS = 5000;
	localparam int RST_MIN_NS = 1;
	localparam int RST_MAX_NS = 100;
	localparam int LOW_CNT_W = 8;
	localparam int RST_MIN_RAW = (RST_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RST_MAX_RAW = (RST_MAX_NS * 1000) / CLK_PERIOD_PS;
	localparam logic [LOW_CNT_W-1:0] RST_MIN_CYC = LOW_CNT_W'((RST_MIN_RAW < 1) ? 1 : RST_MIN_RAW);
	localparam logic [LOW_CNT_W-1:0] RST_MAX_CYC = LOW_CNT_W'((RST_MAX_RAW < 1) ? 1 : RST_MAX_RAW);

	// ****************************************************************
	// state types
	// ****************************************************************
	typedef enum logic [1:0] {
		SAP_CONV_IDLE = 2'b00,
		SAP_CONV_STEP = 2'b01,
		SAP_CONV_STORE = 2'b10
	} sap_conv_e;

	typedef enum logic [1:0] {
		SAP_PWR_RUN = 2'b00,
		SAP_PWR_LOW = 2'b01,
		SAP_PWR_DOWN = 2'b10
	} sap_pwr_e;

endpackage

`default_nettype wire

// ==== sap_serial_port_ctrl.sv ====
// How it works
// - first clock falling edge with select low holds sample, starts conversion unless powered down
// - select low interval frames one exchange
// - output driver enabled while select low
// - serial input sampled on clock falling edges
// - result bits shifted out on falling edges
// - word opens with four-bit channel tag
// - then ten result bits, msb first
// - short low reset pin pulse resets device
// - reset pin held long enters power-down
// - serial clock steps the conversion
// - result read out in following frame
// - sixteen-bit write-only config loaded during readout
// - config written applies to next conversion
`timescale 1ns/1ps
`default_nettype none

module sap_serial_port_ctrl #(
	parameter int BUF_DEPTH = 2,
	parameter int BUF_W = sap_pkg::WORD_W
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic clkEn,
	input wire logic sclk,
	input wire logic csN,
	input wire logic din,
	input wire logic compHigh,
	input wire logic powerdown_reset_n,
	output logic dout,
	output logic doutOe,
	output logic holdMode,
	output logic [sap_pkg::RESULT_W-1:0] dacCode,
	output logic [sap_pkg::CH_W-1:0] muxChannel,
	output logic resultValid,
	output logic [sap_pkg::CH_W-1:0] resultChannel,
	output logic [sap_pkg::RESULT_W-1:0] resultData,
	output logic powerDown
);

	// ****************************************************************
	// state of the serial-clock domain
	// ****************************************************************
	typedef struct packed {
		logic rstS1;
		logic rstS2;
		logic ceS1;
		logic ceS2;
		logic pdS1;
		logic pdS2;
		logic rstTglS1;
		logic rstTglS2;
		logic rstTglSeen;
		logic [sap_pkg::BIT_CNT_W-1:0] bitCnt;
		logic [sap_pkg::CFG_W-1:0] cfgShift;
		logic [sap_pkg::CFG_W-1:0] cfgActive;
		sap_pkg::sap_conv_e conv;
		logic [sap_pkg::CH_W-1:0] convChan;
		logic [sap_pkg::SAR_IDX_W-1:0] sarIdx;
		logic [sap_pkg::RESULT_W-1:0] trial;
		logic hold;
		logic [sap_pkg::FRAME_BITS-1:0] shift;
		logic dout;
		logic [BUF_DEPTH-1:0][BUF_W-1:0] bufMem;
		logic [$clog2(BUF_DEPTH)-1:0] wrPtr;
		logic [$clog2(BUF_DEPTH)-1:0] rdPtr;
		logic [$clog2(BUF_DEPTH):0] bufCnt;
		logic [BUF_W-1:0] lastWord;
		logic [BUF_W-1:0] resWord;
		logic resTgl;
	} sap_link_s;

	// ****************************************************************
	// state of the system-clock domain
	// ****************************************************************
	typedef struct packed {
		logic pinS1;
		logic pinS2;
		logic csS1;
		logic csS2;
		logic resTglS1;
		logic resTglS2;
		logic resTglSeen;
		sap_pkg::sap_pwr_e pwr;
		logic [sap_pkg::LOW_CNT_W-1:0] lowCnt;
		logic powerDown;
		logic rstTgl;
		logic doutOe;
		logic resultValid;
		logic [sap_pkg::CH_W-1:0] resultChannel;
		logic [sap_pkg::RESULT_W-1:0] resultData;
	} sap_sys_s;

	sap_link_s link_r;
	sap_link_s link_nxt;
	sap_sys_s sys_r;
	sap_sys_s sys_nxt;

	localparam logic [$clog2(BUF_DEPTH):0] BUF_FULL = ($clog2(BUF_DEPTH)+1)'(BUF_DEPTH);
	localparam logic [$clog2(BUF_DEPTH)-1:0] PTR_LAST = ($clog2(BUF_DEPTH))'(BUF_DEPTH - 1);

	// ****************************************************************
	// serial-clock domain
	// ****************************************************************
	always_comb begin
		logic frameStart;
		logic push;
		logic pop;
		logic [BUF_W-1:0] word;
		logic [sap_pkg::FRAME_BITS-1:0] frame;
		frameStart = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		word = link_r.lastWord;
		frame = '0;
		link_nxt = link_r;
		link_nxt.rstS1 = rst;
		link_nxt.rstS2 = link_r.rstS1;
		link_nxt.ceS1 = clkEn;
		link_nxt.ceS2 = link_r.ceS1;
		link_nxt.pdS1 = sys_r.powerDown;
		link_nxt.pdS2 = link_r.pdS1;
		link_nxt.rstTglS1 = sys_r.rstTgl;
		link_nxt.rstTglS2 = link_r.rstTglS1;
		if (link_r.rstS2 || (link_r.rstTglS2 != link_r.rstTglSeen)) begin
			link_nxt.rstTglSeen = link_r.rstTglS2;
			link_nxt.bitCnt = '0;
			link_nxt.cfgShift = sap_pkg::CFG_RESET;
			link_nxt.cfgActive = sap_pkg::CFG_RESET;
			link_nxt.conv = sap_pkg::SAP_CONV_IDLE;
			link_nxt.convChan = '0;
			link_nxt.sarIdx = '0;
			link_nxt.trial = '0;
			link_nxt.hold = 1'b0;
			link_nxt.shift = '0;
			link_nxt.dout = 1'b0;
			link_nxt.bufMem = '0;
			link_nxt.wrPtr = '0;
			link_nxt.rdPtr = '0;
			link_nxt.bufCnt = '0;
			link_nxt.lastWord = '0;
			// only system reset clears the toggle, else a pin reset fakes a result
			if (link_r.rstS2) begin
				link_nxt.resTgl = 1'b0;
			end
		end else if (link_r.ceS2) begin
			case (link_r.conv)
				sap_pkg::SAP_CONV_STEP: begin
					if (!compHigh) begin
						link_nxt.trial[link_r.sarIdx] = 1'b0;
					end
					if (link_r.sarIdx == '0) begin
						link_nxt.conv = sap_pkg::SAP_CONV_STORE;
						link_nxt.hold = 1'b0;
					end else begin
						link_nxt.sarIdx = link_r.sarIdx - 1'b1;
						link_nxt.trial[link_r.sarIdx - 1'b1] = 1'b1;
					end
				end
				sap_pkg::SAP_CONV_STORE: begin
					// stalls here while the buffer is full
					if (link_r.bufCnt != BUF_FULL) begin
						push = 1'b1;
						link_nxt.conv = sap_pkg::SAP_CONV_IDLE;
					end
				end
				sap_pkg::SAP_CONV_IDLE: begin
					link_nxt.hold = 1'b0;
				end
				default: begin
					link_nxt.conv = sap_pkg::SAP_CONV_IDLE;
				end
			endcase
			if (!csN) begin
				frameStart = (link_r.bitCnt == '0);
				link_nxt.bitCnt = (link_r.bitCnt == sap_pkg::BIT_CNT_LAST) ? '0
					: link_r.bitCnt + 1'b1;
				link_nxt.cfgShift = {link_r.cfgShift[sap_pkg::CFG_W-2:0], din};
				if (link_r.bitCnt == sap_pkg::BIT_CNT_LAST) begin
					link_nxt.cfgActive = {link_r.cfgShift[sap_pkg::CFG_W-2:0], din};
				end
				link_nxt.dout = link_r.shift[sap_pkg::FRAME_BITS-1];
				link_nxt.shift = {link_r.shift[sap_pkg::FRAME_BITS-2:0], 1'b0};
			end
			if (frameStart) begin
				if (link_r.bufCnt != '0) begin
					pop = 1'b1;
					word = link_r.bufMem[link_r.rdPtr];
					link_nxt.lastWord = word;
				end
				frame = {word, {sap_pkg::PAD_W{1'b0}}};
				link_nxt.dout = frame[sap_pkg::FRAME_BITS-1];
				link_nxt.shift = {frame[sap_pkg::FRAME_BITS-2:0], 1'b0};
			end
			if (frameStart && !link_r.pdS2) begin
				link_nxt.hold = 1'b1;
				link_nxt.conv = sap_pkg::SAP_CONV_STEP;
				link_nxt.convChan = link_r.cfgActive[sap_pkg::CFG_CH_LSB +: sap_pkg::CH_W];
				link_nxt.sarIdx = sap_pkg::SAR_FIRST_IDX;
				link_nxt.trial = sap_pkg::SAR_FIRST_TRIAL;
			end
			if (push) begin
				link_nxt.bufMem[link_r.wrPtr] = {1'b0, link_r.convChan, link_r.trial};
				link_nxt.resWord = {1'b0, link_r.convChan, link_r.trial};
				link_nxt.resTgl = ~link_r.resTgl;
				link_nxt.wrPtr = (link_r.wrPtr == PTR_LAST) ? '0 : link_r.wrPtr + 1'b1;
			end
			if (pop) begin
				link_nxt.rdPtr = (link_r.rdPtr == PTR_LAST) ? '0 : link_r.rdPtr + 1'b1;
			end
			if (push && !pop) begin
				link_nxt.bufCnt = link_r.bufCnt + 1'b1;
			end else if (pop && !push) begin
				link_nxt.bufCnt = link_r.bufCnt - 1'b1;
			end
		end
	end

	always_ff @(negedge sclk) begin
		link_r <= link_nxt;
	end

	// ****************************************************************
	// system-clock domain
	// ****************************************************************
	always_comb begin
		sys_nxt = sys_r;
		sys_nxt.pinS1 = powerdown_reset_n;
		sys_nxt.pinS2 = sys_r.pinS1;
		sys_nxt.csS1 = csN;
		sys_nxt.csS2 = sys_r.csS1;
		sys_nxt.resTglS1 = link_r.resTgl;
		sys_nxt.resTglS2 = sys_r.resTglS1;
		if (rst) begin
			sys_nxt.resTglSeen = 1'b0;
			sys_nxt.pwr = sap_pkg::SAP_PWR_RUN;
			sys_nxt.lowCnt = '0;
			sys_nxt.powerDown = 1'b0;
			sys_nxt.rstTgl = 1'b0;
			sys_nxt.doutOe = 1'b0;
			sys_nxt.resultValid = 1'b0;
			sys_nxt.resultChannel = '0;
			sys_nxt.resultData = '0;
		end else if (clkEn) begin
			sys_nxt.doutOe = ~sys_r.csS2;
			sys_nxt.resultValid = 1'b0;
			if (sys_r.resTglS2 != sys_r.resTglSeen) begin
				sys_nxt.resTglSeen = sys_r.resTglS2;
				sys_nxt.resultValid = 1'b1;
				sys_nxt.resultChannel = link_r.resWord[sap_pkg::RESULT_W +: sap_pkg::CH_W];
				sys_nxt.resultData = link_r.resWord[sap_pkg::RESULT_W-1:0];
			end
			case (sys_r.pwr)
				sap_pkg::SAP_PWR_RUN: begin
					if (!sys_r.pinS2) begin
						sys_nxt.pwr = sap_pkg::SAP_PWR_LOW;
						sys_nxt.lowCnt = 8'h01;
					end
				end
				sap_pkg::SAP_PWR_LOW: begin
					if (sys_r.pinS2) begin
						sys_nxt.pwr = sap_pkg::SAP_PWR_RUN;
						if (sys_r.lowCnt >= sap_pkg::RST_MIN_CYC) begin
							sys_nxt.rstTgl = ~sys_r.rstTgl;
						end
					end else if (sys_r.lowCnt >= sap_pkg::RST_MAX_CYC) begin
						sys_nxt.pwr = sap_pkg::SAP_PWR_DOWN;
						sys_nxt.powerDown = 1'b1;
					end else begin
						sys_nxt.lowCnt = sys_r.lowCnt + 1'b1;
					end
				end
				sap_pkg::SAP_PWR_DOWN: begin
					if (sys_r.pinS2) begin
						sys_nxt.pwr = sap_pkg::SAP_PWR_RUN;
						sys_nxt.powerDown = 1'b0;
						sys_nxt.rstTgl = ~sys_r.rstTgl;
					end
				end
				default: begin
					sys_nxt.pwr = sap_pkg::SAP_PWR_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		sys_r <= sys_nxt;
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign dout = link_r.dout;
	assign holdMode = link_r.hold;
	assign dacCode = link_r.trial;
	assign muxChannel = link_r.convChan;
	assign doutOe = sys_r.doutOe;
	assign resultValid = sys_r.resultValid;
	assign resultChannel = sys_r.resultChannel;
	assign resultData = sys_r.resultData;
	assign powerDown = sys_r.powerDown;

endmodule // sap_serial_port_ctrl

`default_nettype wire

// ==== sap_serial_port_ctrl_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// port checker
// ****
module sap_monitor (
	input wire logic clock,
	input wire logic rst,
	input wire logic csN,
	input wire logic powerdown_reset_n,
	input wire logic doutOe,
	input wire logic resultValid,
	input wire logic powerDown
);
	logic [7:0] lowCnt_r;
	// cycles the pin has been low
	always_ff @(posedge clock) begin
		if (rst || powerdown_reset_n)
			lowCnt_r <= 8'h00;
		else if (lowCnt_r != 8'hff)
			lowCnt_r <= lowCnt_r + 8'h01;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence csLow5; (!csN)[*5]; endsequence
	sequence csHigh5; csN[*5]; endsequence
	sequence pinHigh6; powerdown_reset_n[*6]; endsequence
	oe_on_a: assert property (csLow5 |-> doutOe)
		else $error("driver off in frame");
	oe_off_a: assert property (csHigh5 |-> !doutOe)
		else $error("driver on while idle");
	oe_delay_a: assert property ($fell(csN) |-> !doutOe)
		else $error("driver on before select");
	valid_pulse_a: assert property (resultValid |=> !resultValid)
		else $error("result strobe too long");
	pd_enter_a: assert property (lowCnt_r == 8'h1a |-> powerDown)
		else $error("no power-down on long low");
	pd_cause_a: assert property ($rose(powerDown) |-> lowCnt_r >= 8'h14)
		else $error("power-down too early");
	pd_exit_a: assert property (pinHigh6 |-> !powerDown)
		else $error("power-down stuck");
	pd_short_a: assert property ($rose(powerdown_reset_n) && lowCnt_r < 8'h10 |->
		(!powerDown)[*6])
		else $error("short pulse powered down");
endmodule // sap_monitor

bind sap_serial_port_ctrl sap_monitor sap_monitor_inst (.clock(clock), .rst(rst), .csN(csN),
	.powerdown_reset_n(powerdown_reset_n), .doutOe(doutOe), .resultValid(resultValid),
	.powerDown(powerDown));
`default_nettype wire

// ==== sap_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// host port and comparator
// ****
module sap_host_model (
	output logic sclk,
	output logic csN,
	output logic din,
	output logic compHigh,
	input wire logic dout,
	input wire logic doutOe,
	input wire logic [sap_pkg::RESULT_W-1:0] dacCode
);
	logic [9:0] level = 10'h000;
	initial begin
		sclk = 1'b1;
		csN = 1'b1;
		din = 1'b0;
	end
	// keep trial at or below input
	assign compHigh = (level >= dacCode);
	task automatic frame(input logic [15:0] cfg, input logic [9:0] v, output logic [15:0] got);
		level = v;
		csN = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			din = cfg[i];
			#8 sclk = 1'b0;
			// released line reads as the inverse
			#16 got[i] = doutOe ? dout : ~dout;
			sclk = 1'b1;
			#8;
		end
		csN = 1'b1;
		din = ~din;
		#40;
	endtask
	task automatic idle(input int n);
		repeat (n) begin
			#8 sclk = 1'b0;
			#16 sclk = 1'b1;
			#8;
		end
	endtask
endmodule // sap_host_model
`default_nettype wire

// ==== test_sap_serial_port_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_sap_serial_port_ctrl;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic pdPinN = 1'b1;
	logic sclk, csN, din, compHigh, dout, doutOe, resultValid, powerDown, holdMode;
	logic [9:0] dacCode, resultData, v;
	logic [2:0] resultChannel, muxChannel;
	logic [15:0] got;
	logic [15:0] expWord = 16'h0000;
	logic [2:0] curCh = 3'h0;
	logic [2:0] qCh[$];
	logic [9:0] qVal[$];
	int failures = 0;
	int tests_run = 0;
	always #2.5 clock = ~clock;
	sap_serial_port_ctrl sap_serial_port_ctrl_inst (.clock(clock), .rst(rst), .clkEn(1'b1),
		.sclk(sclk), .csN(csN), .din(din), .compHigh(compHigh), .powerdown_reset_n(pdPinN),
		.dout(dout), .doutOe(doutOe), .holdMode(holdMode), .dacCode(dacCode),
		.muxChannel(muxChannel),
		.resultValid(resultValid), .resultChannel(resultChannel), .resultData(resultData),
		.powerDown(powerDown));
	sap_host_model sap_host_model_inst (.sclk(sclk), .csN(csN), .din(din),
		.compHigh(compHigh), .dout(dout), .doutOe(doutOe), .dacCode(dacCode));
	// ****
	// checks
	// ****
	task automatic check(input logic [15:0] exp, input logic [15:0] act);
		tests_run++;
		if (exp !== act) begin
			failures++;
			$display("[FAIL] %0t: expected %h got %h", $time, exp, act);
		end
	endtask
	task automatic conclude();
		$display("failures=%0d tests_run=%0d", failures, tests_run);
		if (failures == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic runFrame(input logic [15:0] cfg, input logic [9:0] val);
		// result strobe comes inside this frame
		qCh.push_back(curCh);
		qVal.push_back(val);
		fork
			sap_host_model_inst.frame(cfg, val, got);
			begin
				@(negedge sclk);
				#1 check({12'h000, 1'b1, curCh}, {12'h000, holdMode, muxChannel});
				repeat (10) @(negedge sclk);
				#1 check({6'h00, val}, {6'h00, dacCode});
				check(16'h0000, {15'h0000, holdMode});
			end
		join
		check(expWord, got);
		expWord = {1'b0, curCh, val, 2'b00};
		curCh = cfg[2:0];
	endtask
	task automatic drain();
		int n;
		n = 0;
		while (qVal.size() != 0 && n < 200) begin
			@(posedge clock);
			n++;
		end
		check(16'h0000, 16'(qVal.size()));
	endtask
	task automatic pinLow(input int n);
		@(posedge clock);
		#1 pdPinN = 1'b0;
		repeat (n) @(posedge clock);
		#1 pdPinN = 1'b1;
	endtask
	always @(negedge clock) begin
		if (resultValid === 1'b1 && qVal.size() == 0)
			check(16'h0001, 16'h0000);
		else if (resultValid === 1'b1)
			check({3'h0, qCh.pop_front(), qVal.pop_front()},
				{3'h0, resultChannel, resultData});
	end
	// ****
	// sequence
	// ****
	initial begin
		void'($urandom(19202));
		fork
			repeat (16) @(posedge clock);
			sap_host_model_inst.idle(4);
		join
		@(posedge clock);
		#1 rst = 1'b0;
		// link sees the release two serial edges late
		sap_host_model_inst.idle(4);
		for (int k = 0; k < 10; k++) begin
			v = (k == 0) ? 10'h3ff : (k == 1) ? 10'h000 : 10'($urandom);
			runFrame({13'($urandom), 3'(k)}, v);
		end
		drain();
		// short pulse: reset only
		pinLow(8);
		sap_host_model_inst.idle(4);
		check(16'h0000, {15'h0000, powerDown});
		expWord = 16'h0000;
		curCh = 3'h0;
		runFrame(16'h0005, 10'h155);
		runFrame(16'h0002, 10'h2aa);
		drain();
		// long low: power-down
		pinLow(30);
		check(16'h0001, {15'h0000, powerDown});
		repeat (8) @(posedge clock);
		#1 check(16'h0000, {15'h0000, powerDown});
		sap_host_model_inst.idle(4);
		expWord = 16'h0000;
		curCh = 3'h0;
		runFrame(16'h0007, 10'h0f0);
		runFrame(16'h0001, 10'h3fe);
		drain();
		conclude();
	end
endmodule // test_sap_serial_port_ctrl
`default_nettype wire
